// >>> rcs_pkg.sv
package rcs_pkg;

	// ----------------------------------------------------------------
	// Register map and widths
	// ----------------------------------------------------------------
	localparam int unsigned RCS_AW = 3;
	localparam int unsigned RCS_DW = 8;
	localparam logic [2:0] RCS_ADDR_ENABLE = 3'h0;
	localparam logic [2:0] RCS_ADDR_CAUSE = 3'h1;
	localparam logic [2:0] RCS_ADDR_CLKSEL = 3'h2;
	localparam logic [2:0] RCS_ADDR_STATUS = 3'h3;
	localparam logic [2:0] RCS_ADDR_LOCK = 3'h4;
	localparam logic [2:0] RCS_ADDR_SWRST = 3'h5;

	// ----------------------------------------------------------------
	// Source enable fields and value after reset
	// ----------------------------------------------------------------
	localparam int unsigned RCS_EN_WDT = 0;
	localparam int unsigned RCS_EN_MCLK = 1;
	localparam int unsigned RCS_EN_CMP = 2;
	localparam int unsigned RCS_EN_CNV = 3;
	localparam int unsigned RCS_EN_SW = 4;
	localparam logic [7:0] RCS_ENABLE_RST = 8'h01;
	localparam logic [7:0] RCS_ENABLE_MASK = 8'h1f;

	// ----------------------------------------------------------------
	// Reset cause fields (also the request vector layout)
	// ----------------------------------------------------------------
	localparam int unsigned RCS_CS_POR = 0;
	localparam int unsigned RCS_CS_MON = 1;
	localparam int unsigned RCS_CS_WDT = 2;
	localparam int unsigned RCS_CS_MCLK = 3;
	localparam int unsigned RCS_CS_CMP = 4;
	localparam int unsigned RCS_CS_CNV = 5;
	localparam int unsigned RCS_CS_PIN = 6;
	localparam int unsigned RCS_CS_SW = 7;
	localparam logic [7:0] RCS_CAUSE_RST = 8'h01;

	// ----------------------------------------------------------------
	// Status fields
	// ----------------------------------------------------------------
	localparam int unsigned RCS_ST_EXT_OK = 2;
	localparam int unsigned RCS_ST_PLL_OK = 3;
	localparam int unsigned RCS_ST_LOCK = 4;
	localparam int unsigned RCS_ST_SUPPLY_MONITOR_ENABLE_PIN = 5;
	localparam int unsigned RCS_ST_POR = 6;
	localparam int unsigned RCS_ST_SYSRST = 7;

	// ----------------------------------------------------------------
	// Counts and keys
	// ----------------------------------------------------------------
	localparam logic [7:0] RCS_STRETCH_CYC = 8'h10;
	localparam logic [2:0] RCS_ECHO_CYC = 3'h7;
	localparam logic [7:0] RCS_LOCK_KEY = 8'ha5;

	// ----------------------------------------------------------------
	// Synchroniser lanes
	// ----------------------------------------------------------------
	localparam int unsigned RCS_SY_W = 9;
	localparam int unsigned RCS_SY_MON = 0;
	localparam int unsigned RCS_SY_SUPPLY_MONITOR_ENABLE_PIN = 1;
	localparam int unsigned RCS_SY_WDT = 2;
	localparam int unsigned RCS_SY_MCLK = 3;
	localparam int unsigned RCS_SY_CMP = 4;
	localparam int unsigned RCS_SY_CNV = 5;
	localparam int unsigned RCS_SY_PIN = 6;
	localparam int unsigned RCS_SY_EXT = 7;
	localparam int unsigned RCS_SY_PLL = 8;

	// System clock source, also the selector state
	typedef enum logic [1:0] {RCS_CLK_INT, RCS_CLK_EXT, RCS_CLK_PLL} rcs_clk_src_e;

endpackage

// >>> rcs_clk_if.sv
`timescale 1ns/1ns
interface rcs_clk_if;
	import rcs_pkg::*;
	rcs_clk_src_e req;
	logic req_valid;
	logic sys_rst;
	logic ext_ok;
	logic pll_ok;
	rcs_clk_src_e cur;

	modport ctrl (output req, output req_valid, output sys_rst, output ext_ok,
		output pll_ok, input cur);
	modport sel (input req, input req_valid, input sys_rst, input ext_ok,
		input pll_ok, output cur);
endinterface

// >>> rcs_sync.sv
`timescale 1ns/1ns
module rcs_sync
	import rcs_pkg::*;
#(
	parameter int unsigned W = RCS_SY_W
)
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// ----------------------------------------------------------------
	// Two-stage synchroniser; first stage feeds only the second
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// >>> rcs_clk_sel.sv
`timescale 1ns/1ns
module rcs_clk_sel
	import rcs_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	rcs_clk_if.sel cif
);
	rcs_clk_src_e state_q;
	rcs_clk_src_e state_d;

	// ----------------------------------------------------------------
	// Source selection; a source that is not running is never taken
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			RCS_CLK_EXT:
				if (!cif.ext_ok) state_d = RCS_CLK_INT; // Lost oscillator: fall back
			RCS_CLK_PLL:
				if (!cif.pll_ok) state_d = RCS_CLK_INT;
			default:
				state_d = RCS_CLK_INT;
		endcase
		if (cif.req_valid)
		begin
			case (cif.req)
				RCS_CLK_INT: state_d = RCS_CLK_INT; // RULE_09
				RCS_CLK_EXT: if (cif.ext_ok) state_d = RCS_CLK_EXT; // RULE_08
				RCS_CLK_PLL: if (cif.pll_ok) state_d = RCS_CLK_PLL;
				default: state_d = state_q;
			endcase
		end
		if (cif.sys_rst)
			state_d = RCS_CLK_INT; // RULE_07
	end

	// State register doubles as the selector output
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			state_q <= RCS_CLK_INT; // RULE_07
		else
			state_q <= state_d;
	end

	assign cif.cur = state_q;
endmodule

// >>> rcs_top.sv
`timescale 1ns/1ns
// Overview of operation
// RULE_01 - Seven sources merge into one system reset
// RULE_02 - External low on reset pin resets device
// RULE_03 - Power-on reset driven out on reset pin
// RULE_04 - Software can disable all other sources (the code gives the reset pin request no software enable)
// RULE_05 - Supply monitor gated only by enable pin
// RULE_06 - Software may lock watchdog reset on
// RULE_07 - Internal oscillator selected after any reset
// RULE_08 - Software switches to external oscillator live
// RULE_09 - Software switches back to internal anytime
// RULE_10 - Watchdog lock cleared only by power-on
// RULE_11 - Reset held while requests active, released synchronously
module rcs_top
	import rcs_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [RCS_AW-1:0] reg_addr_in,
	input wire logic [RCS_DW-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [RCS_DW-1:0] reg_rdata_out,
	input wire logic supply_monitor_enable_pin_in,
	input wire logic supply_fault_in,
	input wire logic watchdog_expire_in,
	input wire logic missing_clock_in,
	input wire logic level_comparator_a_in,
	input wire logic conversion_start_input_a_in,
	input wire logic reset_pin_n_in,
	output logic reset_pin_n_out,
	output logic reset_pin_oe_out,
	input wire logic ext_osc_valid_in,
	input wire logic pll_lock_in,
	output logic sys_rst_out,
	output logic [1:0] clk_src_out
);
	logic [RCS_SY_W-1:0] raw_w;
	logic [RCS_SY_W-1:0] sy_w;
	logic [7:0] en_q;
	logic [7:0] cause_q;
	logic [7:0] req_w;
	logic [7:0] cnt_q;
	logic [2:0] echo_q;
	logic [7:0] rdata_d;
	logic sys_rst_q;
	logic por_q;
	logic lock_q;
	logic sw_q;
	logic any_req;
	logic pin_req;
	logic wr_en;
	logic wr_cause;
	logic wr_clksel;
	logic wr_lock;
	logic wr_swrst;

	rcs_clk_if cif ();

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Reset pin is inverted so every request lane idles low
	assign raw_w[RCS_SY_MON] = supply_fault_in;
	assign raw_w[RCS_SY_SUPPLY_MONITOR_ENABLE_PIN] = supply_monitor_enable_pin_in;
	assign raw_w[RCS_SY_WDT] = watchdog_expire_in;
	assign raw_w[RCS_SY_MCLK] = missing_clock_in;
	assign raw_w[RCS_SY_CMP] = level_comparator_a_in;
	assign raw_w[RCS_SY_CNV] = conversion_start_input_a_in;
	assign raw_w[RCS_SY_PIN] = ~reset_pin_n_in;
	assign raw_w[RCS_SY_EXT] = ext_osc_valid_in;
	assign raw_w[RCS_SY_PLL] = pll_lock_in;

	rcs_sync #(
		.W(RCS_SY_W)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.async_in(raw_w),
		.sync_out(sy_w)
	);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	assign wr_en = reg_wr_in && (reg_addr_in == RCS_ADDR_ENABLE);
	assign wr_cause = reg_wr_in && (reg_addr_in == RCS_ADDR_CAUSE);
	assign wr_clksel = reg_wr_in && (reg_addr_in == RCS_ADDR_CLKSEL);
	assign wr_lock = reg_wr_in && (reg_addr_in == RCS_ADDR_LOCK);
	assign wr_swrst = reg_wr_in && (reg_addr_in == RCS_ADDR_SWRST);

	// ----------------------------------------------------------------
	// Reset request combiner
	// ----------------------------------------------------------------
	// Our own pin drive echoes back through the pad; ignore it for a while
	assign pin_req = sy_w[RCS_SY_PIN] && !por_q && (echo_q == 3'h0); // RULE_02

	// Monitor has no software gate, only its enable pin
	assign req_w[RCS_CS_POR] = 1'b0;
	assign req_w[RCS_CS_MON] = sy_w[RCS_SY_MON] && sy_w[RCS_SY_SUPPLY_MONITOR_ENABLE_PIN]; // RULE_05
	assign req_w[RCS_CS_WDT] = sy_w[RCS_SY_WDT] && en_q[RCS_EN_WDT]; // RULE_04
	assign req_w[RCS_CS_MCLK] = sy_w[RCS_SY_MCLK] && en_q[RCS_EN_MCLK]; // RULE_04
	assign req_w[RCS_CS_CMP] = sy_w[RCS_SY_CMP] && en_q[RCS_EN_CMP]; // RULE_04
	assign req_w[RCS_CS_CNV] = sy_w[RCS_SY_CNV] && en_q[RCS_EN_CNV]; // RULE_04
	assign req_w[RCS_CS_PIN] = pin_req; // RULE_02
	assign req_w[RCS_CS_SW] = sw_q;
	assign any_req = |req_w; // RULE_01

	// Stretch counter restarts on every request, so reset holds throughout
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			cnt_q <= RCS_STRETCH_CYC;
		else if (any_req)
			cnt_q <= RCS_STRETCH_CYC; // RULE_11
		else if (cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end

	// System reset, released only on a clock edge
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			sys_rst_q <= 1'b1;
		else
			sys_rst_q <= any_req || (cnt_q != 8'h00); // RULE_11
	end

	// ----------------------------------------------------------------
	// Reset pin drive
	// ----------------------------------------------------------------
	// Power-on reset is driven out until its stretch ends, then never again
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			por_q <= 1'b1;
		else if (!any_req && (cnt_q == 8'h00))
			por_q <= 1'b0; // RULE_03
	end

	// Echo blanking covers the pad and synchroniser delay after release
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			echo_q <= RCS_ECHO_CYC;
		else if (por_q)
			echo_q <= RCS_ECHO_CYC;
		else if (echo_q != 3'h0)
			echo_q <= echo_q - 3'h1;
	end

	// Open-drain pad: drive low while enabled
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			reset_pin_oe_out <= 1'b1;
			reset_pin_n_out <= 1'b0;
		end
		else
		begin
			reset_pin_oe_out <= por_q && (any_req || (cnt_q != 8'h00)); // RULE_03
			reset_pin_n_out <= !(por_q && (any_req || (cnt_q != 8'h00)));
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Enables return to defaults on any system reset; the lock forces watchdog
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			en_q <= RCS_ENABLE_RST;
		else if (sys_rst_q)
			en_q <= RCS_ENABLE_RST;
		else if (wr_en)
			en_q <= (reg_wdata_in & RCS_ENABLE_MASK) | (8'(lock_q) << RCS_EN_WDT); // RULE_06
		else if (lock_q)
			en_q[RCS_EN_WDT] <= 1'b1; // RULE_06
	end

	// Lock survives every reset but power-on; keyed so a stray write misses
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			lock_q <= 1'b0; // RULE_10
		else if (wr_lock && (reg_wdata_in == RCS_LOCK_KEY))
			lock_q <= 1'b1; // RULE_06
	end

	// Software reset pulse, honoured only when its enable is set
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			sw_q <= 1'b0;
		else
			sw_q <= wr_swrst && reg_wdata_in[0] && en_q[RCS_EN_SW] && !sys_rst_q; // RULE_04
	end

	// Cause flags: set wins over write-one-to-clear
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			cause_q <= RCS_CAUSE_RST;
		else if (wr_cause)
			cause_q <= (cause_q & ~reg_wdata_in) | req_w;
		else
			cause_q <= cause_q | req_w; // RULE_01
	end

	// ----------------------------------------------------------------
	// Clock source selection
	// ----------------------------------------------------------------
	assign cif.req = rcs_clk_src_e'(reg_wdata_in[1:0]);
	assign cif.req_valid = wr_clksel; // RULE_08
	assign cif.sys_rst = sys_rst_q; // RULE_07
	assign cif.ext_ok = sy_w[RCS_SY_EXT];
	assign cif.pll_ok = sy_w[RCS_SY_PLL];

	rcs_clk_sel u_clk_sel (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.cif(cif.sel)
	);

	assign clk_src_out = cif.cur;
	assign sys_rst_out = sys_rst_q;

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_d = 8'h00;
		case (reg_addr_in)
			RCS_ADDR_ENABLE: rdata_d = en_q;
			RCS_ADDR_CAUSE: rdata_d = cause_q;
			RCS_ADDR_CLKSEL: rdata_d = {6'h00, cif.cur};
			RCS_ADDR_STATUS:
			begin
				rdata_d[1:0] = cif.cur;
				rdata_d[RCS_ST_EXT_OK] = sy_w[RCS_SY_EXT];
				rdata_d[RCS_ST_PLL_OK] = sy_w[RCS_SY_PLL];
				rdata_d[RCS_ST_LOCK] = lock_q;
				rdata_d[RCS_ST_SUPPLY_MONITOR_ENABLE_PIN] = sy_w[RCS_SY_SUPPLY_MONITOR_ENABLE_PIN];
				rdata_d[RCS_ST_POR] = por_q;
				rdata_d[RCS_ST_SYSRST] = sys_rst_q;
			end
			RCS_ADDR_LOCK: rdata_d = {7'h00, lock_q};
			default: rdata_d = 8'h00;
		endcase
	end

	// Data stand for exactly the cycle after the read strobe
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
			reg_rdata_out <= rdata_d;
		else
			reg_rdata_out <= 8'h00;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	AST_SRC_RESETS: assert property (any_req |=> sys_rst_q && ((cause_q & $past(req_w)) == $past(req_w))) // RULE_01
		else $error("Active source did not reset or log cause");
	AST_PIN_ACCEPT: assert property (pin_req |=> sys_rst_out && cause_q[RCS_CS_PIN]) // RULE_02
		else $error("Reset pin request not taken");
	AST_POR_DRIVE: assert property (reset_pin_oe_out |-> !reset_pin_n_out && sys_rst_out) // RULE_03
		else $error("Reset pin drive without system reset");
	AST_QUIET_STAYS: assert property (!any_req && cnt_q == 8'h00 && !sys_rst_q |=> !sys_rst_q) // RULE_04
		else $error("Reset without an enabled source");
	AST_MON_PIN: assert property (sy_w[RCS_SY_MON] && sy_w[RCS_SY_SUPPLY_MONITOR_ENABLE_PIN] |=> sys_rst_q ##0 cause_q[RCS_CS_MON]) // RULE_05
		else $error("Supply monitor not honoured");
	AST_LOCK_FORCE: assert property (lock_q |=> en_q[RCS_EN_WDT]) // RULE_06
		else $error("Locked watchdog enable dropped");
	AST_LOCK_STICKS: assert property (lock_q |=> lock_q) // RULE_10
		else $error("Watchdog lock cleared without power-on");
	AST_CLK_DEFAULT: assert property (sys_rst_q |=> clk_src_out == RCS_CLK_INT) // RULE_07
		else $error("Clock not internal after reset");
	AST_CLK_EXT: assert property (wr_clksel && reg_wdata_in[1:0] == 2'h1 && sy_w[RCS_SY_EXT]
		&& !sys_rst_q |=> clk_src_out == RCS_CLK_EXT) // RULE_08
		else $error("Switch to external oscillator missed");
	AST_CLK_BACK: assert property (wr_clksel && reg_wdata_in[1:0] == 2'h0 |=> clk_src_out == RCS_CLK_INT) // RULE_09
		else $error("Switch back to internal oscillator missed");
	AST_RELEASE: assert property ($fell(sys_rst_q) |-> $past(cnt_q) == 8'h00 && !$past(any_req)
		&& $past(cnt_q, 2) == 8'h01) // RULE_11
		else $error("System reset released early");

	COV_WDT_RESET: cover property (sy_w[RCS_SY_WDT] && en_q[RCS_EN_WDT] ##1 sys_rst_q);
	COV_PIN_RESET: cover property (pin_req ##1 sys_rst_q);
	COV_EXT_SWITCH: cover property (clk_src_out == RCS_CLK_INT ##1 clk_src_out == RCS_CLK_EXT);
	COV_LOCK: cover property ($rose(lock_q));
endmodule

// >>> rcs_board.sv
`timescale 1ns/1ns
// ----------------------------------------
// Board side: pulled-up reset line, two oscillators
// ----------------------------------------
module rcs_board
#(
	parameter int START_CYC = 6
)
(
	input wire logic clk_in,
	input wire logic pin_n_in,
	input wire logic pin_oe_in,
	input wire logic pull_in,
	input wire logic ext_run_in,
	input wire logic pll_run_in,
	output logic pin_level_out,
	output logic ext_ok_out,
	output logic pll_ok_out
);
	int ext_cnt = 0;
	int pll_cnt = 0;
	// Open drain with pull-up, either party may pull low
	assign pin_level_out = !((pin_oe_in && !pin_n_in) || pull_in);
	// Oscillators report running only after start-up, never at once
	always @(posedge clk_in)
	begin
		ext_cnt <= ext_run_in ? ext_cnt + int'(ext_cnt < START_CYC) : 0;
		pll_cnt <= pll_run_in ? pll_cnt + int'(pll_cnt < 2 * START_CYC) : 0;
	end
	assign ext_ok_out = (ext_cnt == START_CYC);
	assign pll_ok_out = (pll_cnt == 2 * START_CYC);
endmodule

// >>> rcs_top_bench.sv
`timescale 1ns/1ns
module rcs_top_bench;
	import rcs_pkg::*;
	logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, supply_monitor_enable_pin = 0, fault = 0, pull = 0;
	logic ext_run = 0, pll_run = 0, pin, ext_ok, pll_ok, pin_n, pin_oe, sys_rst;
	logic [2:0] addr = 0;
	logic [7:0] wdata = 0, rdata, v;
	logic [3:0] src = 0;
	logic [1:0] clk_src;
	int errors = 0, cmp_count = 0, n, m_en, m_cause;
	int en_bit[4] = '{RCS_EN_WDT, RCS_EN_MCLK, RCS_EN_CMP, RCS_EN_CNV};
	int cs_bit[4] = '{RCS_CS_WDT, RCS_CS_MCLK, RCS_CS_CMP, RCS_CS_CNV};
	// ----------------------------------------
	// Clock, design and board
	// ----------------------------------------
	always #4 clk = ~clk;
	rcs_top dut (.mclk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
		.supply_monitor_enable_pin_in(supply_monitor_enable_pin), .supply_fault_in(fault),
		.watchdog_expire_in(src[0]), .missing_clock_in(src[1]),
		.level_comparator_a_in(src[2]), .conversion_start_input_a_in(src[3]),
		.reset_pin_n_in(pin), .reset_pin_n_out(pin_n), .reset_pin_oe_out(pin_oe),
		.ext_osc_valid_in(ext_ok), .pll_lock_in(pll_ok), .sys_rst_out(sys_rst),
		.clk_src_out(clk_src));
	rcs_board board (.clk_in(clk), .pin_n_in(pin_n), .pin_oe_in(pin_oe), .pull_in(pull),
		.ext_run_in(ext_run), .pll_run_in(pll_run), .pin_level_out(pin),
		.ext_ok_out(ext_ok), .pll_ok_out(pll_ok));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Bus cycles end one edge after the strobe, so strobes never collide
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1;
		@(posedge clk);
		wr_s <= 0;
		#1;
	endtask
	task automatic rd(logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1;
		@(posedge clk);
		rd_s <= 0;
		#1 d = rdata;
	endtask
	task automatic wait_rst(logic lvl, int lim, output int cnt);
		cnt = 0;
		while (sys_rst !== lvl && cnt < lim)
		begin
			@(posedge clk);
			#1 cnt++;
		end
		check("sys_rst", 8'(sys_rst), 8'(lvl));
	endtask
	task automatic por();
		@(posedge clk);
		rst <= 1;
		repeat (4) @(posedge clk);
		#1 check("pin held", 8'(pin), 0);
		@(posedge clk);
		rst <= 0;
		wait_rst(0, 40, n);
		check("stretch", 8'(n), RCS_STRETCH_CYC + 1);
		check("pin freed", 8'({pin, pin_oe}), 8'h2);
		check("clk after por", 8'(clk_src), 0);
		m_en = RCS_ENABLE_RST;
		m_cause = RCS_CAUSE_RST;
	endtask
	// Source pulse of random length, long enough to pass the synchroniser
	task automatic pulse(int b, bit hit);
		@(posedge clk);
		src[b] <= 1;
		repeat (3 + $urandom % 5) @(posedge clk);
		src[b] <= 0;
		if (hit)
		begin
			wait_rst(1, 8, n);
			wait_rst(0, 60, n);
			m_en = RCS_ENABLE_RST;
			m_cause = 1 << cs_bit[b];
		end
	endtask
	task automatic clr_cause();
		wr(RCS_ADDR_CAUSE, 8'hff);
		m_cause = 0;
	endtask
	task automatic sel(logic [1:0] s, logic [1:0] exp);
		wr(RCS_ADDR_CLKSEL, {6'h0, s});
		check("clk_src", 8'(clk_src), 8'(exp));
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		#200000 errors++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(32'hc314e286));
		por();
		rd(RCS_ADDR_ENABLE, v);
		check("enable", v, 8'(m_en));
		rd(3'h6, v);
		check("unmapped", v, 0);
		$display("power-on test done");
		for (int b = 0; b < 4; b++)
		begin
			clr_cause();
			wr(RCS_ADDR_ENABLE, 8'($urandom) & RCS_ENABLE_MASK & ~(8'h1 << en_bit[b]));
			pulse(b, 0);
			repeat (6) @(posedge clk);
			#1 check("masked", 8'(sys_rst), 0);
			wr(RCS_ADDR_ENABLE, 8'h1 << en_bit[b]);
			pulse(b, 1);
			rd(RCS_ADDR_CAUSE, v);
			check("cause", v, 8'(m_cause));
			rd(RCS_ADDR_ENABLE, v);
			check("enable", v, 8'(m_en));
		end
		$display("source test done");
		clr_cause();
		@(posedge clk);
		fault <= 1;
		repeat (8) @(posedge clk);
		#1 check("monitor off", 8'(sys_rst), 0);
		@(posedge clk);
		fault <= 0;
		supply_monitor_enable_pin <= 1;
		// Enable pin needs two edges through the synchroniser
		repeat (2) @(posedge clk);
		rd(RCS_ADDR_STATUS, v);
		check("supply_monitor_enable_pin", 8'(v[RCS_ST_SUPPLY_MONITOR_ENABLE_PIN]), 1);
		@(posedge clk);
		fault <= 1;
		wait_rst(1, 8, n);
		@(posedge clk);
		fault <= 0;
		wait_rst(0, 60, n);
		rd(RCS_ADDR_CAUSE, v);
		check("cause", v, 8'(1 << RCS_CS_MON));
		clr_cause();
		@(posedge clk);
		pull <= 1;
		repeat (5) @(posedge clk);
		pull <= 0;
		wait_rst(1, 8, n);
		wait_rst(0, 60, n);
		rd(RCS_ADDR_CAUSE, v);
		check("cause", v, 8'(1 << RCS_CS_PIN));
		$display("monitor and pin test done");
		ext_run <= 1;
		pll_run <= 1;
		repeat (20) @(posedge clk);
		sel(2'h1, 2'h1);
		sel(2'h0, 2'h0);
		sel(2'h2, 2'h2);
		ext_run <= 0;
		repeat (6) @(posedge clk);
		sel(2'h1, 2'h2);
		sel(2'h0, 2'h0);
		ext_run <= 1;
		repeat (20) @(posedge clk);
		sel(2'h1, 2'h1);
		clr_cause();
		// Software reset with its enable still clear must do nothing
		wr(RCS_ADDR_SWRST, 8'h01);
		repeat (4) @(posedge clk);
		#1 check("sw masked", 8'(sys_rst), 0);
		wr(RCS_ADDR_ENABLE, 8'h1 << RCS_EN_SW);
		wr(RCS_ADDR_SWRST, 8'h01);
		wait_rst(1, 8, n);
		wait_rst(0, 60, n);
		check("clk after sw", 8'(clk_src), 0);
		rd(RCS_ADDR_CAUSE, v);
		check("cause", v, 8'(1 << RCS_CS_SW));
		$display("clock and software reset test done");
		wr(RCS_ADDR_LOCK, RCS_LOCK_KEY);
		wr(RCS_ADDR_ENABLE, 8'h0);
		rd(RCS_ADDR_ENABLE, v);
		check("locked enable", v, 8'h01);
		clr_cause();
		pulse(0, 1);
		rd(RCS_ADDR_CAUSE, v);
		check("cause", v, 8'(m_cause));
		rd(RCS_ADDR_LOCK, v);
		check("lock kept", 8'(v[0]), 1);
		por();
		rd(RCS_ADDR_LOCK, v);
		check("lock cleared", 8'(v[0]), 0);
		wr(RCS_ADDR_ENABLE, 8'h0);
		rd(RCS_ADDR_ENABLE, v);
		check("unlocked enable", v, 0);
		$display("lock test done");
		give_verdict();
	end
endmodule
